// >>> shared/sac_pkg.sv
`default_nettype none
package sac_pkg;
    // ***************************************************************
    // Frame layout
    // ***************************************************************
    localparam int FRAME_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 8;
    localparam int LEVEL_MSB = 7;
    localparam int LEVEL_LSB = 0;
    localparam int TAP_BITS = 7;
    localparam logic [15:0] FRAME_RESET = 16'h0000;

    // ***************************************************************
    // Channel addresses
    // ***************************************************************
    localparam logic [7:0] ADDR_CH0 = 8'h00;
    localparam logic [7:0] ADDR_CH1 = 8'h01;
    localparam logic [7:0] ADDR_CH2 = 8'h02;
    localparam int DEFAULT_CHANNELS = 2;

    // ***************************************************************
    // Attenuation code ranges
    // ***************************************************************
    localparam logic [7:0] FINE_MAX = 8'h5F;
    localparam logic [7:0] COARSE_MIN = 8'h60;
    localparam logic [7:0] COARSE_MAX = 8'h7E;
    localparam logic [7:0] MUTE_MIN = 8'h7F;
    // Coarse region: half-dB value is twice the code less this offset
    localparam logic [8:0] COARSE_OFFSET = 9'h060;
    localparam logic [6:0] MUTE_TAP = 7'h7F;
    // Mute reported as 100 dB in half-dB units
    localparam logic [7:0] MUTE_HALF_DB = 8'hC8;

    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_EN_SETUP_NS = 150;
    localparam int EN_SETUP_CYC =
        (T_EN_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 3;
endpackage
`default_nettype wire

// >>> rtl/sac_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sac_sync #(
    parameter int STAGES = 3
) (
    // Clock
    input wire logic clk,
    // Asynchronous level in
    input wire logic asyncIn,
    // Synchronised levels out
    output logic syncOut,
    output logic prevOut
);
    logic [STAGES-1:0] stage;

    if (STAGES < 3) begin : g_bad_stages
        $error("sac_sync needs at least three stages");
    end

    always_ff @(posedge clk) begin
        stage <= {stage[STAGES-2:0], asyncIn};
    end

    assign syncOut = stage[STAGES-1];
    assign prevOut = stage[STAGES-2];
endmodule
`default_nettype wire

// >>> rtl/sac_control_port.sv
`timescale 1ns/1ps
`default_nettype none
module sac_control_port #(
    parameter int NUM_CH = sac_pkg::DEFAULT_CHANNELS
) (
    // System clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial link pins
    input wire logic serialClk,
    input wire logic loadShiftN,
    input wire logic dataIn,
    output logic dataOut,
    // Decoded channel settings
    output logic [NUM_CH-1:0] chanMuted,
    output logic [NUM_CH-1:0][6:0] chanTap,
    output logic [NUM_CH-1:0][7:0] chanHalfDb,
    // Last latched command
    output logic [7:0] channelSelectByte,
    output logic [7:0] attenuationLevelByte,
    output logic cmdStrobe
);
    if (NUM_CH < 1 || NUM_CH > 256) begin : g_bad_channels
        $error("sac_control_port supports 1 to 256 channels");
    end

    // ***************************************************************
    // Serial clock domain
    // ***************************************************************
    logic linkRst;
    logic [sac_pkg::FRAME_BITS-1:0] shiftReg;
    logic shifting;
    logic [sac_pkg::FRAME_BITS-1:0] next_shiftReg;

    sac_sync #(
        .STAGES(sac_pkg::SYNC_STAGES)
    ) u_link_rst_sync (
        .clk(serialClk),
        .asyncIn(rst),
        .syncOut(linkRst),
        .prevOut()
    );

    // Enable is set up well ahead of the first edge by the host
    assign shifting = !loadShiftN;
    // MSB enters first, so it ends nearest data-out
    assign next_shiftReg =
        {shiftReg[sac_pkg::FRAME_BITS-2:0], dataIn};

    always_ff @(posedge serialClk) begin
        if (linkRst) begin
            shiftReg <= sac_pkg::FRAME_RESET;
        end else if (shifting) begin
            shiftReg <= next_shiftReg;
        end
    end

    // Last stage drives the chain onward
    assign dataOut = shiftReg[sac_pkg::FRAME_BITS-1];

    // ***************************************************************
    // Run of consecutive shifting edges, for the data-out check
    // ***************************************************************
    localparam int RUN_W = $clog2(sac_pkg::FRAME_BITS + 1);
    logic [RUN_W-1:0] runLen;

    always_ff @(posedge serialClk) begin
        if (linkRst || !shifting) begin
            runLen <= '0;
        end else if (runLen != RUN_W'(sac_pkg::FRAME_BITS)) begin
            runLen <= runLen + RUN_W'(1);
        end
    end

    // ***************************************************************
    // Enable crossing into the system clock domain
    // ***************************************************************
    logic enNew;
    logic enOld;
    logic enFilt;
    logic enRise;
    logic applyCmd;
    logic enAgree;

    sac_sync #(
        .STAGES(sac_pkg::SYNC_STAGES)
    ) u_enable_sync (
        .clk(ref_clk),
        .asyncIn(loadShiftN),
        .syncOut(enNew),
        .prevOut(enOld)
    );

    assign enAgree = (enOld == enNew);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enFilt <= 1'b1;
            enRise <= 1'b0;
            applyCmd <= 1'b0;
            cmdStrobe <= 1'b0;
        end else begin
            if (enAgree) begin
                enFilt <= enNew;
            end
            enRise <= enAgree && enNew && !enFilt;
            applyCmd <= enRise;
            cmdStrobe <= applyCmd;
        end
    end

    // ***************************************************************
    // Command latch
    // ***************************************************************
    // Shift register is frozen while the enable is high, so it can be
    // sampled here once the rise has been seen.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            channelSelectByte <= sac_pkg::ADDR_CH0;
            attenuationLevelByte <= sac_pkg::MUTE_MIN;
        end else if (enRise) begin
            channelSelectByte <=
                shiftReg[sac_pkg::ADDR_MSB:sac_pkg::ADDR_LSB];
            attenuationLevelByte <=
                shiftReg[sac_pkg::LEVEL_MSB:sac_pkg::LEVEL_LSB];
        end
    end

    // ***************************************************************
    // Level decode
    // ***************************************************************
    logic codeFine;
    logic codeCoarse;
    logic codeMute;
    logic [8:0] coarseWide;
    logic [7:0] next_halfDb;
    logic [6:0] next_tap;
    logic [NUM_CH-1:0] chanHit;

    assign codeFine = (attenuationLevelByte <= sac_pkg::FINE_MAX);
    assign codeMute = (attenuationLevelByte >= sac_pkg::MUTE_MIN);
    assign codeCoarse = !codeFine && !codeMute;
    assign coarseWide =
        {attenuationLevelByte, 1'b0} - sac_pkg::COARSE_OFFSET;
    assign next_halfDb =
        codeMute ? sac_pkg::MUTE_HALF_DB :
        codeCoarse ? coarseWide[7:0] : attenuationLevelByte;
    assign next_tap =
        codeMute ? sac_pkg::MUTE_TAP :
        attenuationLevelByte[sac_pkg::TAP_BITS-1:0];

    // Addresses beyond the channel count match nothing
    for (genvar g = 0; g < NUM_CH; g++) begin : g_hit
        assign chanHit[g] =
            applyCmd && (channelSelectByte == 8'(g));
    end

    // ***************************************************************
    // Channel settings
    // ***************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int k = 0; k < NUM_CH; k++) begin
                chanMuted[k] <= 1'b1;
                chanTap[k] <= sac_pkg::MUTE_TAP;
                chanHalfDb[k] <= sac_pkg::MUTE_HALF_DB;
            end
        end else begin
            for (int k = 0; k < NUM_CH; k++) begin
                if (chanHit[k]) begin
                    chanMuted[k] <= codeMute;
                    chanTap[k] <= next_tap;
                    chanHalfDb[k] <= next_halfDb;
                end
            end
        end
    end

    // ***************************************************************
    // Assertions
    // ***************************************************************
    a_dout_last_stage: assert property (
        @(posedge serialClk) disable iff (rst || linkRst)
        shifting && runLen >= RUN_W'(sac_pkg::FRAME_BITS - 1)
        |=> dataOut == $past(dataIn, sac_pkg::FRAME_BITS))
        else $error("data-out is not the input delayed by 16 shifts");

    a_shift_out_old: assert property (
        @(posedge serialClk) disable iff (rst || linkRst)
        shifting |=> dataOut == $past(shiftReg[sac_pkg::FRAME_BITS-2]))
        else $error("data-out did not advance by one stage");

    a_capture_input: assert property (
        @(posedge serialClk) disable iff (rst || linkRst)
        shifting |=> shiftReg[0] == $past(dataIn))
        else $error("serial input bit not captured");

    a_hold_when_high: assert property (
        @(posedge serialClk) disable iff (rst || linkRst)
        loadShiftN |=> $stable(shiftReg))
        else $error("shift register moved while enable high");

    a_latch_on_rise: assert property (
        @(posedge ref_clk) disable iff (rst)
        enRise |=> channelSelectByte ==
            $past(shiftReg[sac_pkg::ADDR_MSB:sac_pkg::ADDR_LSB]) &&
            attenuationLevelByte ==
            $past(shiftReg[sac_pkg::LEVEL_MSB:sac_pkg::LEVEL_LSB]))
        else $error("command not latched on enable rise");

    a_latch_only_rise: assert property (
        @(posedge ref_clk) disable iff (rst)
        !$past(enRise) |-> $stable(channelSelectByte) &&
            $stable(attenuationLevelByte))
        else $error("command changed without enable rise");

    a_mute_at_reset: assert property (
        @(posedge ref_clk)
        rst |=> chanMuted == {NUM_CH{1'b1}})
        else $error("channels not muted after reset");

    a_mute_code: assert property (
        @(posedge ref_clk) disable iff (rst)
        applyCmd && channelSelectByte == sac_pkg::ADDR_CH0 &&
            attenuationLevelByte >= sac_pkg::MUTE_MIN
        |=> chanMuted[0] && chanTap[0] == sac_pkg::MUTE_TAP)
        else $error("mute code did not mute channel");

    a_fine_step: assert property (
        @(posedge ref_clk) disable iff (rst)
        applyCmd && channelSelectByte == sac_pkg::ADDR_CH0 &&
            attenuationLevelByte <= sac_pkg::FINE_MAX
        |=> !chanMuted[0] &&
            chanHalfDb[0] == $past(attenuationLevelByte))
        else $error("fine code decoded wrong");

    a_coarse_step: assert property (
        @(posedge ref_clk) disable iff (rst)
        applyCmd && channelSelectByte == sac_pkg::ADDR_CH0 &&
            attenuationLevelByte >= sac_pkg::COARSE_MIN &&
            attenuationLevelByte <= sac_pkg::COARSE_MAX
        |=> !chanMuted[0] && 9'(chanHalfDb[0]) ==
            {$past(attenuationLevelByte), 1'b0} - sac_pkg::COARSE_OFFSET)
        else $error("coarse code decoded wrong");

    a_addr_ch1: assert property (
        @(posedge ref_clk) disable iff (rst)
        applyCmd && channelSelectByte == sac_pkg::ADDR_CH1
        |=> $stable(chanHalfDb[0]) && $stable(chanMuted[0]))
        else $error("second channel address touched first channel");

    a_bad_addr_keep: assert property (
        @(posedge ref_clk) disable iff (rst)
        applyCmd && channelSelectByte >= 8'(NUM_CH)
        |=> $stable(chanHalfDb) && $stable(chanMuted) && $stable(chanTap))
        else $error("unknown address changed a channel");

    a_others_keep: assert property (
        @(posedge ref_clk) disable iff (rst)
        !applyCmd |=> $stable(chanHalfDb) && $stable(chanMuted))
        else $error("channel changed without a command");

    a_strobe_pulse: assert property (
        @(posedge ref_clk) disable iff (rst)
        cmdStrobe == $past(applyCmd))
        else $error("command strobe does not follow the apply step");

    c_frame_ch0: cover property (
        @(posedge ref_clk) disable iff (rst)
        applyCmd && channelSelectByte == sac_pkg::ADDR_CH0);

    c_frame_ch1: cover property (
        @(posedge ref_clk) disable iff (rst)
        applyCmd && channelSelectByte == sac_pkg::ADDR_CH1);

    c_mute_cmd: cover property (
        @(posedge ref_clk) disable iff (rst)
        applyCmd && codeMute);

    c_absent_ch: cover property (
        @(posedge ref_clk) disable iff (rst)
        applyCmd && channelSelectByte == sac_pkg::ADDR_CH2);

    c_long_run: cover property (
        @(posedge serialClk) disable iff (rst || linkRst)
        shifting && runLen == RUN_W'(sac_pkg::FRAME_BITS));
endmodule
`default_nettype wire

// >>> verif/sac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
    // Serial link pins
    output logic serialClk,
    output logic loadShiftN,
    output logic dataIn,
    input wire logic dataOut
);
    logic [63:0] outBits;

    initial begin
        serialClk = 1'b0;
        loadShiftN = 1'b1;
        dataIn = 1'b0;
        outBits = 64'h0;
    end

    // Clocks with enable high; data toggles so a leak shows
    task automatic idle_clocks(input int n);
        repeat (n) begin
            dataIn = ~dataIn;
            #15 serialClk = 1'b1;
            #15 serialClk = 1'b0;
        end
    endtask

    // Shift MSB first, collect data-out before each rise
    task automatic shift(input logic [63:0] bits, input int nbits,
            input int slow);
        outBits = 64'h0;
        loadShiftN = 1'b0;
        #(160 + slow * 100);
        for (int i = nbits - 1; i >= 0; i--) begin
            dataIn = bits[i];
            outBits = {outBits[62:0], dataOut};
            #15 serialClk = 1'b1;
            #15 serialClk = 1'b0;
        end
        dataIn = ~dataIn;
        #20 loadShiftN = 1'b1;
        #220;
    endtask
endmodule
`default_nettype wire

// >>> verif/serial_attenuator_control_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_attenuator_control_port_bench;
    // ***************************************************************
    // Pins and scoreboard
    // ***************************************************************
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic serialClk, loadShiftN, dataIn, dataOut, cmdStrobe;
    logic [1:0] chanMuted;
    logic [1:0][6:0] chanTap;
    logic [1:0][7:0] chanHalfDb;
    logic [7:0] selByte, lvlByte;
    int mdlHalf[2] = '{200, 200};
    int mdlTap[2] = '{127, 127};
    logic mdlMute[2] = '{1'b1, 1'b1};
    logic [15:0] mdlReg = 16'h0000;
    logic [63:0] expOut;
    logic [31:0] seed = 32'h582D;
    logic [7:0] codes[10] = '{8'h00, 8'h01, 8'h5F, 8'h60, 8'h61,
        8'h7E, 8'h7F, 8'h80, 8'hFE, 8'hFF};
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;

    always #12.5 ref_clk = ~ref_clk;

    sac_control_port #(.NUM_CH(2)) dut (.ref_clk(ref_clk), .rst(rst),
        .serialClk(serialClk), .loadShiftN(loadShiftN), .dataIn(dataIn),
        .dataOut(dataOut), .chanMuted(chanMuted), .chanTap(chanTap),
        .chanHalfDb(chanHalfDb), .channelSelectByte(selByte),
        .attenuationLevelByte(lvlByte), .cmdStrobe(cmdStrobe));

    sac_host_model host (.serialClk(serialClk), .loadShiftN(loadShiftN),
        .dataIn(dataIn), .dataOut(dataOut));

    // ***************************************************************
    // Compare tasks
    // ***************************************************************
    task automatic chk_val(input string name, input logic [63:0] exp,
            input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic chk_chan(input int c);
        chk_val("muted", {63'h0, mdlMute[c]}, {63'h0, chanMuted[c]});
        chk_val("tap", 64'(mdlTap[c]), {57'h0, chanTap[c]});
        chk_val("halfDb", 64'(mdlHalf[c]), {56'h0, chanHalfDb[c]});
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // ***************************************************************
    // One transfer with model update and checks
    // ***************************************************************
    task automatic send(input logic [63:0] bits, input int nbits,
            input int slow);
        int n;
        logic strb;
        logic [7:0] a;
        logic [7:0] l;
        n = 0;
        strb = 1'b0;
        expOut = 64'h0;
        for (int i = nbits - 1; i >= 0; i--) begin
            expOut = {expOut[62:0], mdlReg[15]};
            mdlReg = {mdlReg[14:0], bits[i]};
        end
        a = mdlReg[15:8];
        l = mdlReg[7:0];
        fork
            host.shift(bits, nbits, slow);
            begin
                @(posedge loadShiftN);
                while (cmdStrobe !== 1'b1 && n < 12) begin
                    @(posedge ref_clk);
                    #1;
                    n++;
                end
                strb = cmdStrobe;
            end
        join
        if (a < 8'h02) begin
            mdlMute[a] = (l >= 8'h7F);
            mdlTap[a] = (l >= 8'h7F) ? 127 : int'(l);
            mdlHalf[a] = (l <= 8'h5F) ? int'(l) :
                (l <= 8'h7E) ? 2 * int'(l) - 96 : 200;
        end
        chk_val("strobe", 64'h1, {63'h0, strb});
        chk_val("latency", 64'h1, {63'h0, (n >= 3 && n <= 8)});
        chk_val("dataOut", expOut, host.outBits);
        chk_val("selByte", {56'h0, a}, {56'h0, selByte});
        chk_val("lvlByte", {56'h0, l}, {56'h0, lvlByte});
        chk_chan(0);
        chk_chan(1);
    endtask

    // ***************************************************************
    // Timeout and main sequence
    // ***************************************************************
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        fork
            begin
                repeat (16) @(posedge ref_clk);
                #2 rst = 1'b0;
            end
            host.idle_clocks(8);
        join
        // Link reset only lets go once the serial clock runs
        host.idle_clocks(4);
        repeat (4) @(posedge ref_clk);
        #1;
        chk_chan(0);
        chk_chan(1);
        $display("test reset done");
        for (int c = 0; c < 2; c++) begin
            foreach (codes[i]) send({48'h0, 8'(c), codes[i]}, 16, 0);
        end
        $display("test decode done");
        repeat (12) begin
            seed = lfsr_step(seed);
            send({48'h0, 7'h0, seed[8], seed[7:0]}, 16, int'(seed[9]));
            send({48'h0, seed[15:8] | 8'h02, seed[23:16]}, 16, 0);
        end
        $display("test random done");
        host.idle_clocks(5);
        send({48'h0, 8'h01, 8'h30}, 16, 0);
        send({48'h0, 8'h02, 8'h10}, 16, 0);
        $display("test idle done");
        seed = lfsr_step(seed);
        send({32'h0, seed[31:16], 8'h00, seed[7:0]}, 32, 0);
        $display("test chain done");
        final_report();
    end
endmodule
`default_nettype wire
